//--- sse_dmem.sv
// Data memory: one write port, two registered read ports
`default_nettype none
module sse_dmem
    import sse_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               we,
    input  wire logic [DMEM_AW-1:0] waddr,
    input  wire logic [7:0]         wdata,
    input  wire logic [DMEM_AW-1:0] raddr_a,
    output logic      [7:0]         rdata_a,
    input  wire logic [DMEM_AW-1:0] raddr_b,
    output logic      [7:0]         rdata_b
);
    logic [7:0] mem [DMEM_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule // sse_dmem
`default_nettype wire

//--- sse_exec.sv
// Skip-if-nonzero and subtract execution unit with accumulator and flags
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`default_nettype none
module sse_exec
    import sse_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               instr_valid,
    input  wire logic [2:0]         instr_op,
    input  wire logic [DMEM_AW-1:0] instr_addr,
    input  wire logic [2:0]         instr_bit,
    input  wire logic [7:0]         instr_imm,
    output logic                    instr_ready,
    output logic                    done_pulse,
    output logic                    skip_taken,
    output logic                    dummy_cycle,
    output logic      [7:0]         acc_out,
    output logic      [5:0]         flags_out,
    input  wire logic [7:0]         sw_addr,
    input  wire logic [7:0]         sw_wdata,
    input  wire logic               sw_wr,
    input  wire logic               sw_rd,
    output logic      [7:0]         sw_rdata
);
    // Difference in the low byte, flags word above it
    function automatic logic [13:0] sub8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        logic       wrap;
        logic       z;
        logic [5:0] flg;
        // One adder for all three subtracts keeps the flags consistent
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        wrap = (a[7] != b[7]) && (full[7] != a[7]);
        z    = (full[7:0] == 8'h00);
        // Carry out set means no borrow
        flg           = 6'h00;
        flg[FLG_C]    = full[8];
        flg[FLG_HALF] = low[4];
        flg[FLG_Z]    = z;
        flg[FLG_WRAP] = wrap;
        flg[FLG_SBOR] = wrap ^ full[7];
        flg[FLG_CNIL] = z;
        return {flg, full[7:0]};
    endfunction

    sse_state_t         state_q, state_d;
    sse_op_t            op_q;
    logic [DMEM_AW-1:0] addr_q;
    logic [2:0]         bit_q;
    logic [7:0]         imm_q;
    logic [7:0]         acc_q;
    logic [5:0]         flags_q;
    logic [7:0]         reg_rdata_q;
    logic               rd_mem_q;

    logic [7:0]  mem_rdata;
    logic [7:0]  mem_sw_rdata;
    logic        in_exec;
    logic        is_sub;
    logic [7:0]  operand_b;
    logic [13:0] sub_res;
    logic [7:0]  diff;
    logic        tested_nz;
    logic        is_skip;
    logic        core_we;
    logic        sw_hit_mem;
    logic        sw_hit_acc;
    logic        mem_we;
    logic [DMEM_AW-1:0] mem_waddr;
    logic [7:0]  mem_wdata;

    assign in_exec    = (state_q == ST_EXEC);
    assign is_sub     = (op_q == OP_SUB_MEM) || (op_q == OP_SUB_TO_MEM) || (op_q == OP_SUB_IMM);
    assign is_skip    = (op_q == OP_SKIP_BIT) || (op_q == OP_SKIP_BYTE);
    assign operand_b  = (op_q == OP_SUB_IMM) ? imm_q : mem_rdata;
    assign sub_res    = sub8(acc_q, operand_b);
    assign diff       = sub_res[7:0];
    assign tested_nz  = (op_q == OP_SKIP_BIT)  ? mem_rdata[bit_q] :
                        (op_q == OP_SKIP_BYTE) ? (mem_rdata != 8'h00) : 1'b0;
    assign skip_taken = in_exec && is_skip && tested_nz;
    assign dummy_cycle = (state_q == ST_DUMMY);
    assign done_pulse = (in_exec && !skip_taken) || dummy_cycle;
    assign instr_ready = (state_q == ST_IDLE);

    // Core write wins over a same-cycle software write to memory
    assign core_we    = in_exec && (op_q == OP_SUB_TO_MEM);
    assign sw_hit_mem = (sw_addr[7:DMEM_AW] == OFS_MEM_BASE[7:DMEM_AW]);
    assign sw_hit_acc = (sw_addr == OFS_ACC);
    assign mem_we     = core_we || (sw_wr && sw_hit_mem);
    assign mem_waddr  = core_we ? addr_q : sw_addr[DMEM_AW-1:0];
    assign mem_wdata  = core_we ? diff : sw_wdata;
    assign acc_out    = acc_q;
    assign flags_out  = flags_q;
    assign sw_rdata   = rd_mem_q ? mem_sw_rdata : reg_rdata_q;

    sse_dmem u_dmem (
        .clk     (clk),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr_a (addr_q),
        .rdata_a (mem_rdata),
        .raddr_b (sw_addr[DMEM_AW-1:0]),
        .rdata_b (mem_sw_rdata)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  state_d = instr_valid ? ST_FETCH : ST_IDLE;
            ST_FETCH: state_d = ST_EXEC;
            ST_EXEC:  state_d = skip_taken ? ST_DUMMY : ST_IDLE;
            ST_DUMMY: state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            op_q    <= OP_NOP;
            addr_q  <= '0;
            bit_q   <= 3'h0;
            imm_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            if (instr_ready && instr_valid) begin
                op_q   <= sse_op_t'(instr_op);
                addr_q <= instr_addr;
                bit_q  <= instr_bit;
                imm_q  <= instr_imm;
            end
        end
    end

    // Core update of the accumulator beats a software write in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_q   <= RST_ACC;
            flags_q <= RST_FLAGS;
        end else begin
            if (in_exec && is_sub) begin
                flags_q <= sub_res[13:8];
            end
            if (in_exec && ((op_q == OP_SUB_MEM) || (op_q == OP_SUB_IMM))) begin
                acc_q <= diff;
            end else if (sw_wr && sw_hit_acc) begin
                acc_q <= sw_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata_q <= RST_RDATA;
            rd_mem_q    <= 1'b0;
        end else begin
            rd_mem_q    <= sw_rd && sw_hit_mem;
            reg_rdata_q <= !sw_rd ? RST_RDATA :
                           sw_hit_acc ? acc_q :
                           (sw_addr == OFS_FLAGS) ? {2'b00, flags_q} : RST_RDATA;
        end
    end

    // Checks
    skip_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && op_q == OP_SKIP_BIT |-> skip_taken == mem_rdata[bit_q])
        else $error("bit skip decision wrong");

    skip_byte_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && op_q == OP_SKIP_BYTE && mem_rdata != 8'h00 |-> skip_taken)
        else $error("byte skip not taken");

    dummy_slot_a: assert property (@(posedge clk) disable iff (sys_rst)
        skip_taken |-> !done_pulse ##1 dummy_cycle && done_pulse ##1 instr_ready)
        else $error("skip dummy cycle missing");

    no_skip_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && is_skip && !tested_nz |-> done_pulse && !skip_taken ##1 instr_ready && !dummy_cycle)
        else $error("zero value caused skip");

    acc_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && op_q == OP_SUB_MEM |=> acc_q == 8'($past(acc_q) - $past(mem_rdata)))
        else $error("accumulator subtract wrong");

    borrow_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && is_sub |=> flags_q[FLG_C] == ($past(acc_q) >= $past(operand_b)))
        else $error("borrow flag wrong");

    nil_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && is_sub |=> flags_q[FLG_Z] == ($past(acc_q) == $past(operand_b))
            && flags_q[FLG_CNIL] == flags_q[FLG_Z]
            && flags_q[FLG_SBOR] == ($signed($past(acc_q)) < $signed($past(operand_b))))
        else $error("zero or signed flag wrong");

    mem_store_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && op_q == OP_SUB_TO_MEM |-> mem_we && mem_waddr == addr_q
            && mem_wdata == 8'(acc_q - mem_rdata) ##1 acc_q == $past(acc_q))
        else $error("memory store subtract wrong");

    imm_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && op_q == OP_SUB_IMM |=> acc_q == 8'($past(acc_q) - $past(imm_q)))
        else $error("immediate subtract wrong");

    half_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
        in_exec && is_sub |=> flags_q[FLG_HALF] == ($past(acc_q[3:0]) >= $past(operand_b[3:0]))
            && flags_q[FLG_WRAP] == (($signed($past(acc_q)) - $signed($past(operand_b))) > 127
            || ($signed($past(acc_q)) - $signed($past(operand_b))) < -128))
        else $error("half borrow or overflow wrong");
endmodule // sse_exec
`default_nettype wire

//--- sse_pkg.sv
// Shared constants, opcodes and states for the skip and subtract execution unit
`default_nettype none
package sse_pkg;
    localparam int          DMEM_AW      = 4;
    localparam int          DMEM_DEPTH   = 16;
    localparam logic [7:0]  OFS_ACC      = 8'h00;
    localparam logic [7:0]  OFS_FLAGS    = 8'h01;
    localparam logic [7:0]  OFS_MEM_BASE = 8'h10;
    localparam logic [7:0]  RST_ACC      = 8'h00;
    localparam logic [5:0]  RST_FLAGS    = 6'h00;
    localparam logic [7:0]  RST_RDATA    = 8'h00;
    // Flag bit positions in the flags word
    localparam int          FLG_C        = 0;
    localparam int          FLG_HALF     = 1;
    localparam int          FLG_Z        = 2;
    localparam int          FLG_WRAP     = 3;
    localparam int          FLG_SBOR     = 4;
    localparam int          FLG_CNIL     = 5;

    typedef enum logic [2:0] {
        OP_NOP        = 3'b000,
        OP_SKIP_BIT   = 3'b001,
        OP_SKIP_BYTE  = 3'b010,
        OP_SUB_MEM    = 3'b011,
        OP_SUB_TO_MEM = 3'b100,
        OP_SUB_IMM    = 3'b101
    } sse_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b10,
        ST_DUMMY = 2'b11
    } sse_state_t;
endpackage
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the skip and subtract execution unit
`default_nettype none
module tb_top
    import sse_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk         = 1'b0;
    logic               sys_rst     = 1'b1;
    logic               instr_valid = 1'b0;
    logic [2:0]         instr_op    = 3'h0;
    logic [DMEM_AW-1:0] instr_addr  = '0;
    logic [2:0]         instr_bit   = 3'h0;
    logic [7:0]         instr_imm   = 8'h00;
    logic [7:0]         sw_addr     = 8'h00;
    logic [7:0]         sw_wdata    = 8'h00;
    logic               sw_wr       = 1'b0;
    logic               sw_rd       = 1'b0;
    logic               instr_ready, done_pulse, skip_taken, dummy_cycle;
    logic [7:0]         acc_out, sw_rdata, r;
    logic [5:0]         flags_out;
    logic [7:0]         m_acc = 8'h00;
    logic [7:0]         m_mem [DMEM_DEPTH];
    logic [5:0]         m_flg = 6'h00;
    int                 err_total = 0;
    int                 samples_checked = 0;

    sse_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_addr(instr_addr), .instr_bit(instr_bit), .instr_imm(instr_imm), .instr_ready(instr_ready),
        .done_pulse(done_pulse), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle), .acc_out(acc_out),
        .flags_out(flags_out), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata));

    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Borrow-style subtract: carry set means no borrow
    function automatic logic [5:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        int         sd;
        logic [5:0] f;
        d = a - b;
        sd = int'($signed(a)) - int'($signed(b));
        f = 6'h00;
        f[FLG_C] = (a >= b);
        f[FLG_HALF] = (a[3:0] >= b[3:0]);
        f[FLG_Z] = (d == 8'h00);
        f[FLG_WRAP] = (sd > 127) || (sd < -128);
        f[FLG_SBOR] = (sd < 0);
        f[FLG_CNIL] = (d == 8'h00);
        return f;
    endfunction

    task automatic swr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        if (a == OFS_ACC) m_acc = d;
        if (a[7:DMEM_AW] == OFS_MEM_BASE[7:DMEM_AW]) m_mem[a[DMEM_AW-1:0]] = d;
    endtask

    task automatic srd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    task automatic ex(input logic [2:0] op, input logic [3:0] a, input logic [2:0] b, input logic [7:0] imm);
        logic [7:0] v, opnd, d;
        logic       sk, saw, dm;
        int         n;
        v = m_mem[a];
        sk = (op == 3'h1) ? v[b] : (op == 3'h2) ? (v != 8'h00) : 1'b0;
        @(posedge clk);
        instr_op <= op;
        instr_addr <= a;
        instr_bit <= b;
        instr_imm <= imm;
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        n = 0;
        saw = 1'b0;
        dm = 1'b0;
        do begin
            @(posedge clk);
            #1 n++;
            if (skip_taken === 1'b1) saw = 1'b1;
            dm = dummy_cycle;
        end while (done_pulse !== 1'b1 && n < 6);
        chk("latency", sk ? 8'h02 : 8'h01, 8'(n));
        chk("skip", {7'h00, sk}, {7'h00, saw});
        chk("dummy", {7'h00, sk}, {7'h00, dm});
        if (op >= 3'h3 && op <= 3'h5) begin
            opnd = (op == 3'h5) ? imm : v;
            d = m_acc - opnd;
            m_flg = sub_flags(m_acc, opnd);
            if (op == 3'h4) m_mem[a] = d;
            else m_acc = d;
        end
        @(posedge clk);
        #1 chk("acc", m_acc, acc_out);
        chk("flags", {2'h0, m_flg}, {2'h0, flags_out});
        chk("ready", 8'h01, {7'h00, instr_ready});
        if (op == 3'h4) begin
            srd({4'h1, a}, r);
            chk("mem", m_mem[a], r);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        end_sim();
    end

    initial begin
        void'($urandom(56059));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk("acc rst", RST_ACC, acc_out);
        chk("flags rst", {2'h0, RST_FLAGS}, {2'h0, flags_out});
        $display("test reset done");
        // Flags are read-only, unmapped reads give zero
        swr(OFS_FLAGS, 8'hff);
        srd(OFS_FLAGS, r);
        chk("flags ro", {2'h0, RST_FLAGS}, r);
        srd(8'h05, r);
        chk("unmapped", 8'h00, r);
        for (int i = 0; i < DMEM_DEPTH; i++) swr(OFS_MEM_BASE + 8'(i), 8'($urandom));
        swr(8'h10, 8'h00);
        swr(8'h11, 8'h01);
        $display("test swport done");
        swr(OFS_ACC, 8'h80);
        ex(3'h2, 4'h0, 3'h0, 8'h00);
        ex(3'h1, 4'h1, 3'h0, 8'h00);
        ex(3'h1, 4'h1, 3'h1, 8'h00);
        ex(3'h2, 4'h1, 3'h0, 8'h00);
        ex(3'h5, 4'h0, 3'h0, 8'h01);
        ex(3'h5, 4'h0, 3'h0, 8'h7f);
        ex(3'h4, 4'h1, 3'h0, 8'h00);
        ex(3'h3, 4'h1, 3'h0, 8'h00);
        srd(OFS_ACC, r);
        chk("acc read", m_acc, r);
        $display("test corners done");
        repeat (300) begin
            if ($urandom_range(3) == 0) swr(OFS_ACC, 8'($urandom));
            ex(3'($urandom_range(7)), 4'($urandom), 3'($urandom), 8'($urandom));
        end
        for (int i = 0; i < DMEM_DEPTH; i++) begin
            srd(OFS_MEM_BASE + 8'(i), r);
            chk("mem final", m_mem[i], r);
        end
        $display("test random done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
